// *** hw/iswds_top.sv ***
// control sequencer of the isolated switch driver
`timescale 1ns/100ps
// Functional notes
// - two-wire: enable high starts power-up, enable current charges primary
// - at primary peak level, transfer energy for one fixed 3.3 us burst
// - repeat charge then burst until both secondary rails are charged
// - once both secondary rails charged, gate drive goes high while enable stays high
// - enable low: gate drive commanded low before primary hits lockout
// - burst length fixed, period set hysteretically by primary peak level
// - seven current levels picked by resistor, captured once at power-up
// - primary undervoltage stops all transfer to secondary rails
// - primary undervoltage: signal gate low, else timeout forces it low
// - either secondary rail in lockout holds gate drive low
// - lockouts use hysteresis; only the secondary lockout ignores brief switching dips
// - two- or three-wire mode decided at power-up, kept until power cycle
// - three-wire early enable that lifts primary still allows transfer
// - overtemperature stops transfer until temperature falls to re-engage
// - overtemperature with primary still powered forces gate drive low
// - standard enable: gate drive follows enable once rails are powered
module iswds_top
    import iswds_pkg::*;
#(
    parameter int UV_TIMEOUT_CYCLES = UV_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // analog comparator results, asynchronous
    input wire iswds_cmp_t cmp_in,
    // decoded transfer level resistor, asynchronous strap
    input wire logic [LEVEL_W-1:0] transfer_level_select,
    // gate drive and status
    output logic gate_drive_out,
    output logic transfer_active,
    output logic two_wire_mode,
    output logic thermal_shutdown,
    output logic [LEVEL_W-1:0] level_sel,
    output logic [CURRENT_W-1:0] current_limit_ua,
    output iswds_state_t seq_state
);
    localparam int TO_W = $clog2(UV_TIMEOUT_CYCLES + 1);
    localparam int BC_W = $clog2(BURST_CYCLES);
    localparam int GC_W = $clog2(GLITCH_CYCLES + 1);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    initial if (UV_TIMEOUT_CYCLES < 1) $error("iswds_top: bad timeout");

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    logic [CMP_W-1:0] cmp_vec;
    iswds_cmp_t cmp;
    logic [LEVEL_W-1:0] level_sync;

    iswds_sync #(.W(CMP_W)) u_sync_cmp (.clk(clk), .arst_n(arst_n),
        .d(cmp_in), .q(cmp_vec));
    assign cmp = iswds_cmp_t'(cmp_vec);

    iswds_sync #(.W(LEVEL_W)) u_sync_lvl (.clk(clk), .arst_n(arst_n),
        .d(transfer_level_select), .q(level_sync));

    // ------------------------------------------------------------------
    // hysteretic levels
    // ------------------------------------------------------------------
    logic en_level;
    logic pri_ok;
    logic hot;
    logic sec_ok;
    logic [GC_W-1:0] dip_cnt;
    logic sec_low;

    assign sec_low = !cmp.high_above_fall || !cmp.mid_above_fall;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_level <= 1'b0;
            pri_ok <= 1'b0;
            hot <= 1'b0;
        end else begin
            if (cmp.en_above_high) begin
                en_level <= 1'b1;
            end else if (!cmp.en_above_low) begin
                en_level <= 1'b0;
            end
            if (cmp.pri_above_rise) begin
                pri_ok <= 1'b1;
            end else if (!cmp.pri_above_fall) begin
                pri_ok <= 1'b0;
            end
            if (cmp.temp_hot) begin
                hot <= 1'b1;
            end else if (cmp.temp_cool) begin
                hot <= 1'b0;
            end
        end
    end

    // secondary lockout: a dip must outlast the switching transient
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_ok <= 1'b0;
            dip_cnt <= '0;
        end else begin
            if (!sec_low) begin
                dip_cnt <= '0;
            end else if (int'(dip_cnt) < GLITCH_CYCLES) begin
                dip_cnt <= dip_cnt + 1'b1;
            end
            if (sec_low && int'(dip_cnt) >= GLITCH_CYCLES - 1) begin
                sec_ok <= 1'b0;
            end else if (cmp.high_above_rise && cmp.mid_above_rise) begin
                sec_ok <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // power-up capture: mode and transfer level
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            two_wire_mode <= 1'b0;
            level_sel <= LEVEL_RESET;
            current_limit_ua <= CURRENT_RESET;
        end else if (seq_state == ST_OFF && cmp.pri_above_rise) begin
            two_wire_mode <= en_level;
            level_sel <= level_clamp(level_sync);
            current_limit_ua <= level_current_ua(level_sync);
        end
    end

    // ------------------------------------------------------------------
    // burst sequencer
    // ------------------------------------------------------------------
    logic [BC_W-1:0] burst_cnt;
    logic may_transfer;
    logic burst_done;

    assign may_transfer = pri_ok && !hot;
    assign burst_done = int'(burst_cnt) == BURST_CYCLES - 1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_state <= ST_OFF;
        end else begin
            case (seq_state)
                ST_OFF: begin
                    if (cmp.pri_above_rise) begin
                        seq_state <= ST_CHARGE;
                    end
                end
                ST_CHARGE: begin
                    if (!pri_ok) begin
                        seq_state <= ST_OFF;
                    end else if (sec_ok) begin
                        seq_state <= ST_HOLD;
                    end else if (may_transfer && cmp.pri_at_peak) begin
                        seq_state <= ST_BURST;
                    end
                end
                ST_BURST: begin
                    if (!may_transfer) begin
                        seq_state <= pri_ok ? ST_CHARGE : ST_OFF;
                    end else if (burst_done) begin
                        seq_state <= ST_CHARGE;
                    end
                end
                ST_HOLD: begin
                    if (!pri_ok) begin
                        seq_state <= ST_OFF;
                    end else if (!sec_ok) begin
                        seq_state <= ST_CHARGE;
                    end
                end
                default: seq_state <= ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_cnt <= '0;
        end else if (seq_state == ST_BURST && !burst_done) begin
            burst_cnt <= burst_cnt + 1'b1;
        end else begin
            burst_cnt <= '0;
        end
    end

    assign transfer_active = seq_state == ST_BURST;
    assign thermal_shutdown = hot;

    // ------------------------------------------------------------------
    // gate drive
    // ------------------------------------------------------------------
    logic [TO_W-1:0] to_cnt;
    logic timed_out;
    logic next_gate;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            to_cnt <= '0;
        end else if (pri_ok) begin
            to_cnt <= '0;
        end else if (!timed_out) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end
    assign timed_out = int'(to_cnt) >= UV_TIMEOUT_CYCLES;

    always_comb begin
        next_gate = gate_drive_out;
        if (!sec_ok) begin
            next_gate = 1'b0;
        end else if (hot && pri_ok) begin
            next_gate = 1'b0;
        end else if (pri_ok) begin
            next_gate = en_level;
        end else if (cmp.pri_can_signal || timed_out) begin
            next_gate = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_drive_out <= 1'b0;
        end else begin
            gate_drive_out <= next_gate;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_burst_len;
        transfer_active && burst_done && may_transfer |=> !transfer_active;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("burst exceeded fixed length");
    property p_burst_start;
        $rose(transfer_active) |-> burst_cnt == '0 && $past(cmp.pri_at_peak);
    endproperty
    a_burst_start: assert property (p_burst_start)
        else $error("burst started without primary peak");
    property p_no_xfer_uv;
        !pri_ok |=> !transfer_active;
    endproperty
    a_no_xfer_uv: assert property (p_no_xfer_uv)
        else $error("transfer during primary lockout");
    property p_hot_stop;
        hot |=> !transfer_active;
    endproperty
    a_hot_stop: assert property (p_hot_stop)
        else $error("transfer during thermal shutdown");
    property p_sec_uv_gate;
        !sec_ok |=> !gate_drive_out;
    endproperty
    a_sec_uv_gate: assert property (p_sec_uv_gate)
        else $error("gate high with secondary rail in lockout");
    property p_hot_gate;
        hot && pri_ok |=> !gate_drive_out;
    endproperty
    a_hot_gate: assert property (p_hot_gate)
        else $error("gate high during thermal shutdown");
    property p_follow_en;
        pri_ok && sec_ok && !hot |=> gate_drive_out == $past(en_level);
    endproperty
    a_follow_en: assert property (p_follow_en)
        else $error("gate does not follow enable");
    property p_timeout;
        timed_out && !pri_ok |=> !gate_drive_out;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("gate high after primary timeout");
    property p_mode_hold;
        seq_state != ST_OFF |=> $stable(two_wire_mode) && $stable(level_sel);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode or level changed while powered");
    property p_dip_ignored;
        sec_ok && $rose(sec_low) |=> sec_ok;
    endproperty
    a_dip_ignored: assert property (p_dip_ignored)
        else $error("brief rail dip caused lockout");

    c_burst: cover property (transfer_active && burst_done);
    c_gate_on: cover property ($rose(gate_drive_out) && two_wire_mode);
    c_timeout: cover property ($fell(gate_drive_out) && timed_out);
    c_hot: cover property ($rose(hot) && gate_drive_out);
endmodule

// *** hw/iswds_pkg.sv ***
// shared constants and types of the isolated switch drive sequencer
package iswds_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int BURST_TIME_PS = 3300000;
    localparam int BURST_CYCLES = BURST_TIME_PS / CLK_PERIOD_PS;
    localparam int GLITCH_TIME_PS = 200000;
    localparam int GLITCH_CYCLES = GLITCH_TIME_PS / CLK_PERIOD_PS;
    localparam int UV_TIMEOUT_DEFAULT = 20000;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // transfer level selection
    // ------------------------------------------------------------------
    localparam int LEVEL_W = 3;
    localparam int LEVEL_COUNT = 7;
    localparam int CURRENT_W = 13;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h0;
    localparam logic [CURRENT_W-1:0] CURRENT_RESET = 13'h076C;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic en_above_high;
        logic en_above_low;
        logic pri_above_rise;
        logic pri_above_fall;
        logic pri_at_peak;
        logic pri_can_signal;
        logic high_above_rise;
        logic high_above_fall;
        logic mid_above_rise;
        logic mid_above_fall;
        logic temp_hot;
        logic temp_cool;
    } iswds_cmp_t;

    localparam int CMP_W = $bits(iswds_cmp_t);

    typedef enum logic [1:0] {
        ST_OFF = 2'h0,
        ST_CHARGE = 2'h1,
        ST_BURST = 2'h3,
        ST_HOLD = 2'h2
    } iswds_state_t;

    // nominal enable input current in microamps; code 7 is out of range
    function automatic logic [CURRENT_W-1:0] level_current_ua(
        input logic [LEVEL_W-1:0] code);
        case (code)
            3'h0: level_current_ua = 13'h076C;
            3'h1: level_current_ua = 13'h0AF0;
            3'h2: level_current_ua = 13'h0E74;
            3'h3: level_current_ua = 13'h1194;
            3'h4: level_current_ua = 13'h1450;
            3'h5: level_current_ua = 13'h1770;
            3'h6: level_current_ua = 13'h1A2C;
            default: level_current_ua = 13'h076C;
        endcase
    endfunction

    function automatic logic [LEVEL_W-1:0] level_clamp(
        input logic [LEVEL_W-1:0] code);
        level_clamp = (int'(code) < LEVEL_COUNT) ? code : LEVEL_RESET;
    endfunction

endpackage

// *** hw/iswds_sync.sv ***
// two-flop synchroniser bank for comparator and strap inputs
`timescale 1ns/100ps
module iswds_sync
    import iswds_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    initial begin
        if (W < 1) $error("iswds_sync: width must be at least 1");
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** test/iswds_ctrl_model.sv ***
// controller that drives the enable input of the sequencer
`timescale 1ns/100ps
module iswds_ctrl_model
    import iswds_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request from the bench
    input wire logic en_req,
    // enable threshold comparisons
    output logic en_above_low,
    output logic en_above_high
);
    // ------------------------------------------------------------------
    // enable ramp
    // ------------------------------------------------------------------
    // rising ramp crosses the low level one cycle before the high level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_above_low <= 1'b0;
            en_above_high <= 1'b0;
        end else begin
            en_above_low <= en_req;
            en_above_high <= en_req & en_above_low;
        end
    end
endmodule

// *** test/iswds_top_test.sv ***
// self-checking bench of the switch drive sequencer
`timescale 1ns/100ps
module iswds_top_test;
    import iswds_pkg::*;
    localparam int UV_TO = 50;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic en_req = 1'b0;
    logic en_hi;
    logic en_lo;
    iswds_cmp_t cmp_d = '0;
    iswds_cmp_t cmp_in;
    logic [LEVEL_W-1:0] strap = 3'h3;
    logic gate_drive_out;
    logic transfer_active;
    logic two_wire_mode;
    logic thermal_shutdown;
    logic [LEVEL_W-1:0] level_sel;
    logic [CURRENT_W-1:0] current_limit_ua;
    iswds_state_t seq_state;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    logic [CURRENT_W-1:0] cur_tab [8] = '{13'h076C, 13'h0AF0, 13'h0E74,
        13'h1194, 13'h1450, 13'h1770, 13'h1A2C, 13'h076C};

    always #2.5 clk = ~clk;

    always_comb begin
        cmp_in = cmp_d;
        cmp_in.en_above_high = en_hi;
        cmp_in.en_above_low = en_lo;
    end

    iswds_ctrl_model u_iswds_ctrl_model (.clk(clk), .arst_n(arst_n),
        .en_req(en_req), .en_above_low(en_lo), .en_above_high(en_hi));

    iswds_top #(.UV_TIMEOUT_CYCLES(UV_TO)) u_iswds_top (.clk(clk),
        .arst_n(arst_n), .cmp_in(cmp_in), .transfer_level_select(strap),
        .gate_drive_out(gate_drive_out), .transfer_active(transfer_active),
        .two_wire_mode(two_wire_mode), .thermal_shutdown(thermal_shutdown),
        .level_sel(level_sel), .current_limit_ua(current_limit_ua),
        .seq_state(seq_state));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %0h, want %0h", $time, seen,
                exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wait_st(input iswds_state_t s);
        for (int i = 0; i < 2000 && seq_state !== s; i++) @(negedge clk);
        chk(seq_state, s);
    endtask

    task automatic pri(input logic v);
        @(posedge clk);
        cmp_d.pri_above_rise <= v;
        cmp_d.pri_above_fall <= v;
    endtask

    task automatic rails(input logic v);
        @(posedge clk);
        cmp_d.high_above_rise <= v;
        cmp_d.high_above_fall <= v;
        cmp_d.mid_above_rise <= v;
        cmp_d.mid_above_fall <= v;
    endtask

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        cyc(2);
        chk(seq_state, ST_OFF);
        chk(current_limit_ua, 13'h076C);
        @(posedge clk);
        arst_n <= 1'b1;
        en_req <= 1'b1;
        cyc(6);
        @(posedge clk) cmp_d.pri_can_signal <= 1'b1;
        pri(1'b1);
        wait_st(ST_CHARGE);
        chk(two_wire_mode, 1'b1);
        chk(level_sel, 3'h3);
        chk(current_limit_ua, 13'h1194);
        chk(gate_drive_out, 1'b0);
        @(posedge clk) strap <= 3'h5;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) cmp_d.pri_at_peak <= 1'b1;
            wait_st(ST_BURST);
            @(posedge clk) cmp_d.pri_at_peak <= 1'b0;
            n = 0;
            while (transfer_active === 1'b1 && n < 2000) begin
                n++;
                @(negedge clk);
            end
            chk(n, BURST_CYCLES);
            chk(seq_state, ST_CHARGE);
        end
        rails(1'b1);
        wait_st(ST_HOLD);
        cyc(2);
        chk(gate_drive_out, 1'b1);
        chk(level_sel, 3'h3);
        $display("test power_up done");
        @(posedge clk) cmp_d.high_above_fall <= 1'b0;
        cyc(10);
        @(posedge clk) cmp_d.high_above_fall <= 1'b1;
        cyc(6);
        chk(gate_drive_out, 1'b1);
        @(posedge clk) cmp_d.mid_above_fall <= 1'b0;
        cyc(50);
        chk(gate_drive_out, 1'b0);
        @(posedge clk) cmp_d.mid_above_fall <= 1'b1;
        cyc(6);
        chk(gate_drive_out, 1'b1);
        $display("test lockout done");
        @(posedge clk) en_req <= 1'b0;
        cyc(6);
        chk(gate_drive_out, 1'b0);
        @(posedge clk) en_req <= 1'b1;
        cyc(7);
        chk(gate_drive_out, 1'b1);
        $display("test enable done");
        @(posedge clk) cmp_d.temp_hot <= 1'b1;
        cyc(5);
        chk(thermal_shutdown, 1'b1);
        chk(gate_drive_out, 1'b0);
        rails(1'b0);
        wait_st(ST_CHARGE);
        @(posedge clk) cmp_d.pri_at_peak <= 1'b1;
        cyc(6);
        chk(transfer_active, 1'b0);
        @(posedge clk) cmp_d.pri_at_peak <= 1'b0;
        rails(1'b1);
        @(posedge clk) cmp_d.temp_hot <= 1'b0;
        @(posedge clk) cmp_d.temp_cool <= 1'b1;
        cyc(6);
        chk(thermal_shutdown, 1'b0);
        chk(gate_drive_out, 1'b1);
        $display("test thermal done");
        @(posedge clk) cmp_d.pri_can_signal <= 1'b0;
        pri(1'b0);
        cyc(5);
        chk(transfer_active, 1'b0);
        chk(gate_drive_out, 1'b1);
        cyc(UV_TO);
        chk(gate_drive_out, 1'b0);
        chk(seq_state, ST_OFF);
        $display("test primary lockout done");
        @(posedge clk) en_req <= 1'b0;
        cyc(4);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk) strap <= 3'(c);
            cyc(4);
            pri(1'b1);
            wait_st(ST_CHARGE);
            chk(two_wire_mode, 1'b0);
            chk(level_sel, (c == 7) ? 3'h0 : 3'(c));
            chk(current_limit_ua, cur_tab[c]);
            pri(1'b0);
            wait_st(ST_OFF);
        end
        pri(1'b1);
        wait_st(ST_CHARGE);
        @(posedge clk) en_req <= 1'b1;
        cyc(7);
        chk(two_wire_mode, 1'b0);
        chk(gate_drive_out, 1'b1);
        @(posedge clk) cmp_d.pri_can_signal <= 1'b1;
        pri(1'b0);
        cyc(5);
        chk(gate_drive_out, 1'b0);
        $display("test three wire done");
        close_out();
    end
endmodule
